// ### verilog/psrc_top.sv
`timescale 1ns/100ps
// How it works
// - high bits 22..19: calibrator, timers 11,10,9
// - high bits 14..9: serial, timers, converters
// - high bits 7,5..2,0: ports, pin multiplexer
// - low bits 31,28,27,25,23: can, power, usb
// - low bits 22..17,14: two-wire, serial ports
// - low bits 11,3..0: watchdog, timers 5..2
// - assigned bits rw, zero at reset, 1 resets
// - no wait states; byte, half, word writes
module psrc_top
   import psrc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [psrc_addr_width-1:0] reg_addr,
   input wire logic [psrc_data_width-1:0] reg_wdata,
   input wire logic [3:0] reg_byte_en,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [psrc_data_width-1:0] reg_rdata,
   output logic [31:0] highspeed_periph_reset,
   output logic [31:0] lowspeed_periph_reset
);

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [31:0] highspeed_bus_peripheral_reset;
   logic [31:0] lowspeed_bus_peripheral_reset;

   // merge enabled bytes, keep reserved positions at zero
   function automatic logic [31:0] psrc_merge(input logic [31:0] old_value, input logic [31:0] new_value,
                                              input logic [3:0] lanes, input logic [31:0] mask);
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++)
      begin
         if (lanes[i])
         begin
            result[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return result & mask;
   endfunction : psrc_merge

   // address decoding shared by the write paths and the read mux
   function automatic logic psrc_hit(input logic [psrc_addr_width-1:0] address,
                                     input logic [psrc_addr_width-1:0] offset);
      return address == offset;
   endfunction : psrc_hit

   // ****************************************************************
   // writable masks, built from the named bit positions
   // ****************************************************************

   // one-hot word for a single bit position
   function automatic logic [31:0] psrc_bit(input int position);
      logic [31:0] result;
      result = '0;
      result[position] = 1'b1;
      return result;
   endfunction : psrc_bit

   // reserved positions never appear here, so they can never be set
   localparam logic [31:0] highspeed_built_mask = psrc_bit(clock_calibrator_reset_bit) |
                                                  psrc_bit(timer_eleven_reset_bit) |
                                                  psrc_bit(timer_ten_reset_bit) |
                                                  psrc_bit(timer_nine_reset_bit) |
                                                  psrc_bit(serial_port_one_reset_bit) |
                                                  psrc_bit(timer_eight_reset_bit) |
                                                  psrc_bit(serial_periph_one_reset_bit) |
                                                  psrc_bit(timer_one_reset_bit) |
                                                  psrc_bit(converter_two_reset_bit) |
                                                  psrc_bit(converter_one_reset_bit) |
                                                  psrc_bit(port_f_reset_bit) |
                                                  psrc_bit(port_d_reset_bit) |
                                                  psrc_bit(port_c_reset_bit) |
                                                  psrc_bit(port_b_reset_bit) |
                                                  psrc_bit(port_a_reset_bit) |
                                                  psrc_bit(pin_multiplexer_reset_bit);

   localparam logic [31:0] lowspeed_built_mask = psrc_bit(controller_area_two_reset_bit) |
                                                 psrc_bit(power_control_reset_bit) |
                                                 psrc_bit(battery_registers_reset_bit) |
                                                 psrc_bit(controller_area_one_reset_bit) |
                                                 psrc_bit(usb_unit_reset_bit) |
                                                 psrc_bit(two_wire_two_reset_bit) |
                                                 psrc_bit(two_wire_one_reset_bit) |
                                                 psrc_bit(serial_port_five_reset_bit) |
                                                 psrc_bit(serial_port_four_reset_bit) |
                                                 psrc_bit(serial_port_three_reset_bit) |
                                                 psrc_bit(serial_port_two_reset_bit) |
                                                 psrc_bit(serial_periph_two_reset_bit) |
                                                 psrc_bit(window_watchdog_reset_bit) |
                                                 psrc_bit(timer_five_reset_bit) |
                                                 psrc_bit(timer_four_reset_bit) |
                                                 psrc_bit(timer_three_reset_bit) |
                                                 psrc_bit(timer_two_reset_bit);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         highspeed_bus_peripheral_reset <= psrc_reset_value;
      end
      else if (reg_write && psrc_hit(reg_addr, highspeed_bus_peripheral_reset_offset))
      begin
         highspeed_bus_peripheral_reset <= psrc_merge(highspeed_bus_peripheral_reset, reg_wdata,
                                                      reg_byte_en, highspeed_built_mask);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         lowspeed_bus_peripheral_reset <= psrc_reset_value;
      end
      else if (reg_write && psrc_hit(reg_addr, lowspeed_bus_peripheral_reset_offset))
      begin
         lowspeed_bus_peripheral_reset <= psrc_merge(lowspeed_bus_peripheral_reset, reg_wdata,
                                                     reg_byte_en, lowspeed_built_mask);
      end
   end

   // ****************************************************************
   // read data, one cycle after the strobe; unmapped reads zero
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         reg_rdata <= psrc_reset_value;
      end
      else if (reg_read && psrc_hit(reg_addr, highspeed_bus_peripheral_reset_offset))
      begin
         reg_rdata <= highspeed_bus_peripheral_reset;
      end
      else if (reg_read && psrc_hit(reg_addr, lowspeed_bus_peripheral_reset_offset))
      begin
         reg_rdata <= lowspeed_bus_peripheral_reset;
      end
      else
      begin
         reg_rdata <= psrc_reset_value;
      end
   end

   // ****************************************************************
   // per-peripheral reset levels, high while held in reset
   // ****************************************************************
   // calibrator and timers on the high-speed bus
   logic calibrator_held;
   logic timer_eleven_held;
   logic timer_ten_held;
   logic timer_nine_held;

   // serial, timers and converters on the high-speed bus
   logic serial_port_one_held;
   logic timer_eight_held;
   logic serial_periph_one_held;
   logic timer_one_held;
   logic converter_two_held;
   logic converter_one_held;

   // ports and pin multiplexer on the high-speed bus
   logic port_f_held;
   logic port_d_held;
   logic port_c_held;
   logic port_b_held;
   logic port_a_held;
   logic pin_multiplexer_held;

   // controller-area, power, battery and usb on the low-speed bus
   logic controller_area_two_held;
   logic power_control_held;
   logic battery_registers_held;
   logic controller_area_one_held;
   logic usb_unit_held;

   // two-wire and serial units on the low-speed bus
   logic two_wire_two_held;
   logic two_wire_one_held;
   logic serial_port_five_held;
   logic serial_port_four_held;
   logic serial_port_three_held;
   logic serial_port_two_held;
   logic serial_periph_two_held;

   // watchdog and timers on the low-speed bus
   logic window_watchdog_held;
   logic timer_five_held;
   logic timer_four_held;
   logic timer_three_held;
   logic timer_two_held;

   // ****************************************************************
   // taps from the register bits
   // ****************************************************************
   assign calibrator_held = highspeed_bus_peripheral_reset[clock_calibrator_reset_bit];
   assign timer_eleven_held = highspeed_bus_peripheral_reset[timer_eleven_reset_bit];
   assign timer_ten_held = highspeed_bus_peripheral_reset[timer_ten_reset_bit];
   assign timer_nine_held = highspeed_bus_peripheral_reset[timer_nine_reset_bit];

   assign serial_port_one_held = highspeed_bus_peripheral_reset[serial_port_one_reset_bit];
   assign timer_eight_held = highspeed_bus_peripheral_reset[timer_eight_reset_bit];
   assign serial_periph_one_held = highspeed_bus_peripheral_reset[serial_periph_one_reset_bit];
   assign timer_one_held = highspeed_bus_peripheral_reset[timer_one_reset_bit];
   assign converter_two_held = highspeed_bus_peripheral_reset[converter_two_reset_bit];
   assign converter_one_held = highspeed_bus_peripheral_reset[converter_one_reset_bit];

   assign port_f_held = highspeed_bus_peripheral_reset[port_f_reset_bit];
   assign port_d_held = highspeed_bus_peripheral_reset[port_d_reset_bit];
   assign port_c_held = highspeed_bus_peripheral_reset[port_c_reset_bit];
   assign port_b_held = highspeed_bus_peripheral_reset[port_b_reset_bit];
   assign port_a_held = highspeed_bus_peripheral_reset[port_a_reset_bit];
   assign pin_multiplexer_held = highspeed_bus_peripheral_reset[pin_multiplexer_reset_bit];

   assign controller_area_two_held = lowspeed_bus_peripheral_reset[controller_area_two_reset_bit];
   assign power_control_held = lowspeed_bus_peripheral_reset[power_control_reset_bit];
   assign battery_registers_held = lowspeed_bus_peripheral_reset[battery_registers_reset_bit];
   assign controller_area_one_held = lowspeed_bus_peripheral_reset[controller_area_one_reset_bit];
   assign usb_unit_held = lowspeed_bus_peripheral_reset[usb_unit_reset_bit];

   assign two_wire_two_held = lowspeed_bus_peripheral_reset[two_wire_two_reset_bit];
   assign two_wire_one_held = lowspeed_bus_peripheral_reset[two_wire_one_reset_bit];
   assign serial_port_five_held = lowspeed_bus_peripheral_reset[serial_port_five_reset_bit];
   assign serial_port_four_held = lowspeed_bus_peripheral_reset[serial_port_four_reset_bit];
   assign serial_port_three_held = lowspeed_bus_peripheral_reset[serial_port_three_reset_bit];
   assign serial_port_two_held = lowspeed_bus_peripheral_reset[serial_port_two_reset_bit];
   assign serial_periph_two_held = lowspeed_bus_peripheral_reset[serial_periph_two_reset_bit];

   assign window_watchdog_held = lowspeed_bus_peripheral_reset[window_watchdog_reset_bit];
   assign timer_five_held = lowspeed_bus_peripheral_reset[timer_five_reset_bit];
   assign timer_four_held = lowspeed_bus_peripheral_reset[timer_four_reset_bit];
   assign timer_three_held = lowspeed_bus_peripheral_reset[timer_three_reset_bit];
   assign timer_two_held = lowspeed_bus_peripheral_reset[timer_two_reset_bit];

   // ****************************************************************
   // peripheral reset outputs, one per bit, active high
   // ****************************************************************
   // reserved positions stay low on the outputs whatever the register holds
   always_comb
   begin
      highspeed_periph_reset = psrc_reset_value;
      // calibrator and timers
      highspeed_periph_reset[clock_calibrator_reset_bit] = calibrator_held;
      highspeed_periph_reset[timer_eleven_reset_bit] = timer_eleven_held;
      highspeed_periph_reset[timer_ten_reset_bit] = timer_ten_held;
      highspeed_periph_reset[timer_nine_reset_bit] = timer_nine_held;

      // serial, timers and converters
      highspeed_periph_reset[serial_port_one_reset_bit] = serial_port_one_held;
      highspeed_periph_reset[timer_eight_reset_bit] = timer_eight_held;
      highspeed_periph_reset[serial_periph_one_reset_bit] = serial_periph_one_held;
      highspeed_periph_reset[timer_one_reset_bit] = timer_one_held;
      highspeed_periph_reset[converter_two_reset_bit] = converter_two_held;
      highspeed_periph_reset[converter_one_reset_bit] = converter_one_held;

      // ports and pin multiplexer
      highspeed_periph_reset[port_f_reset_bit] = port_f_held;
      highspeed_periph_reset[port_d_reset_bit] = port_d_held;
      highspeed_periph_reset[port_c_reset_bit] = port_c_held;
      highspeed_periph_reset[port_b_reset_bit] = port_b_held;
      highspeed_periph_reset[port_a_reset_bit] = port_a_held;
      highspeed_periph_reset[pin_multiplexer_reset_bit] = pin_multiplexer_held;
   end

   always_comb
   begin
      lowspeed_periph_reset = psrc_reset_value;
      // controller-area, power, battery and usb
      lowspeed_periph_reset[controller_area_two_reset_bit] = controller_area_two_held;
      lowspeed_periph_reset[power_control_reset_bit] = power_control_held;
      lowspeed_periph_reset[battery_registers_reset_bit] = battery_registers_held;
      lowspeed_periph_reset[controller_area_one_reset_bit] = controller_area_one_held;
      lowspeed_periph_reset[usb_unit_reset_bit] = usb_unit_held;

      // two-wire and serial units
      lowspeed_periph_reset[two_wire_two_reset_bit] = two_wire_two_held;
      lowspeed_periph_reset[two_wire_one_reset_bit] = two_wire_one_held;
      lowspeed_periph_reset[serial_port_five_reset_bit] = serial_port_five_held;
      lowspeed_periph_reset[serial_port_four_reset_bit] = serial_port_four_held;
      lowspeed_periph_reset[serial_port_three_reset_bit] = serial_port_three_held;
      lowspeed_periph_reset[serial_port_two_reset_bit] = serial_port_two_held;
      lowspeed_periph_reset[serial_periph_two_reset_bit] = serial_periph_two_held;

      // watchdog and timers
      lowspeed_periph_reset[window_watchdog_reset_bit] = window_watchdog_held;
      lowspeed_periph_reset[timer_five_reset_bit] = timer_five_held;
      lowspeed_periph_reset[timer_four_reset_bit] = timer_four_held;
      lowspeed_periph_reset[timer_three_reset_bit] = timer_three_held;
      lowspeed_periph_reset[timer_two_reset_bit] = timer_two_held;
   end

endmodule : psrc_top

// ### verilog/psrc_pkg.sv
// ****************************************************************
// register map and field layout
// ****************************************************************
package psrc_pkg;

   localparam int psrc_addr_width = 4;
   localparam int psrc_data_width = 32;

   // offsets are placed by this block, byte addresses of aligned words
   localparam logic [3:0] highspeed_bus_peripheral_reset_offset = 4'h0;
   localparam logic [3:0] lowspeed_bus_peripheral_reset_offset = 4'h4;

   localparam logic [31:0] psrc_reset_value = 32'h0000_0000;

   // writable bit masks; every other position is reserved and reads zero
   localparam logic [31:0] highspeed_writable_mask = 32'h0078_7ebd;
   localparam logic [31:0] lowspeed_writable_mask = 32'h9afe_480f;

   // high-speed bus bit positions
   localparam int clock_calibrator_reset_bit = 22;
   localparam int timer_eleven_reset_bit = 21;
   localparam int timer_ten_reset_bit = 20;
   localparam int timer_nine_reset_bit = 19;
   localparam int serial_port_one_reset_bit = 14;
   localparam int timer_eight_reset_bit = 13;
   localparam int serial_periph_one_reset_bit = 12;
   localparam int timer_one_reset_bit = 11;
   localparam int converter_two_reset_bit = 10;
   localparam int converter_one_reset_bit = 9;
   localparam int port_f_reset_bit = 7;
   localparam int port_d_reset_bit = 5;
   localparam int port_c_reset_bit = 4;
   localparam int port_b_reset_bit = 3;
   localparam int port_a_reset_bit = 2;
   localparam int pin_multiplexer_reset_bit = 0;

   // low-speed bus bit positions
   localparam int controller_area_two_reset_bit = 31;
   localparam int power_control_reset_bit = 28;
   localparam int battery_registers_reset_bit = 27;
   localparam int controller_area_one_reset_bit = 25;
   localparam int usb_unit_reset_bit = 23;
   localparam int two_wire_two_reset_bit = 22;
   localparam int two_wire_one_reset_bit = 21;
   localparam int serial_port_five_reset_bit = 20;
   localparam int serial_port_four_reset_bit = 19;
   localparam int serial_port_three_reset_bit = 18;
   localparam int serial_port_two_reset_bit = 17;
   localparam int serial_periph_two_reset_bit = 14;
   localparam int window_watchdog_reset_bit = 11;
   localparam int timer_five_reset_bit = 3;
   localparam int timer_four_reset_bit = 2;
   localparam int timer_three_reset_bit = 1;
   localparam int timer_two_reset_bit = 0;

endpackage : psrc_pkg

// ### testbench/psrc_top_props.sv
`timescale 1ns/100ps
module psrc_top_props
   import psrc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [3:0] reg_byte_en,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] highspeed_periph_reset,
   input wire logic [31:0] lowspeed_periph_reset
);
   logic [31:0] h, l;
   logic fw;
   assign h = highspeed_periph_reset;
   assign l = lowspeed_periph_reset;
   assign fw = reg_write && reg_byte_en == 4'hf;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   hs_write_a: assert property (fw && reg_addr == 4'h0 |=> h == ($past(reg_wdata) & 32'h787ebd))
      else $error("hw");
   ls_write_a: assert property (fw && reg_addr == 4'h4 |=> l == ($past(reg_wdata) & 32'h9afe480f))
      else $error("lw");
   hs_hold_a: assert property (!reg_write || reg_addr != 4'h0 |=> $stable(h))
      else $error("hh");
   ls_hold_a: assert property (!reg_write || reg_addr != 4'h4 |=> $stable(l))
      else $error("lh");
   hs_read_a: assert property (reg_read && reg_addr == 4'h0 |=> reg_rdata == $past(h))
      else $error("hr");
   ls_read_a: assert property (reg_read && reg_addr == 4'h4 |=> reg_rdata == $past(l))
      else $error("lr");
   rd_zero_a: assert property (!(reg_read && (reg_addr == 4'h0 || reg_addr == 4'h4)) |=> reg_rdata == 32'h0)
      else $error("rz");
   resv_zero_a: assert property ((h & ~32'h787ebd) == 32'h0 && (l & ~32'h9afe480f) == 32'h0)
      else $error("rv");
   rst_clear_a: assert property (disable iff (1'b0) reset |=> h == 32'h0 && l == 32'h0 && reg_rdata == 32'h0)
      else $error("reset did not clear");
   hs_lane_a: assert property (reg_write && reg_addr == 4'h0 && !reg_byte_en[0] |=> h[7:0] == $past(h[7:0]))
      else $error("disabled lane written");
   ls_lane_a: assert property (reg_write && reg_addr == 4'h4 && !reg_byte_en[3] |=> l[31:24] == $past(l[31:24]))
      else $error("disabled lane written");
endmodule : psrc_top_props
bind psrc_top psrc_top_props i_props (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_byte_en, .reg_write,
   .reg_read, .reg_rdata, .highspeed_periph_reset, .lowspeed_periph_reset);

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic [3:0] reg_addr = 4'h0, reg_byte_en = 4'h0, a, b;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, hs, ls, d, eh, el;
   int fail_count = 0, checks = 0;
   // address, lanes, write data, expected high and low registers
   logic [103:0] rows [5] = '{{4'h0, 4'hf, 32'h787ebd, 32'h787ebd, 32'h0},
      {4'h4, 4'hf, 32'h9afe480f, 32'h787ebd, 32'h9afe480f}, {4'h0, 4'h1, 32'h0, 32'h787e00, 32'h9afe480f},
      {4'h4, 4'hc, 32'h0, 32'h787e00, 32'h480f}, {4'h8, 4'hf, 32'hffffffff, 32'h787e00, 32'h480f}};
   psrc_top i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_byte_en, .reg_write, .reg_read, .reg_rdata,
      .highspeed_periph_reset(hs), .lowspeed_periph_reset(ls));
   task go(input logic [1:0] s, input logic [3:0] ad, be, input logic [31:0] wd);
      @(posedge ref_clk);
      {reg_write, reg_read, reg_addr, reg_byte_en, reg_wdata} <= {s, ad, be, wd};
   endtask : go
   task chk(input logic [31:0] g, e);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wrap_up;
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial forever #10 ref_clk = ~ref_clk;
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         {a, b, d, eh, el} = rows[i];
         go(2'b10, a, b, d);
         go(2'b01, a, b, d);
         go(2'b00, a, b, d);
         @(negedge ref_clk);
         chk(hs, eh);
         chk(ls, el);
         chk(reg_rdata, a == 4'h0 ? eh : a == 4'h4 ? el : 32'h0);
      end
      go(2'b00, a, b, d);
      @(negedge ref_clk);
      chk(reg_rdata, 32'h0);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(hs, 32'h0);
      chk(ls, 32'h0);
      @(posedge ref_clk);
      reset <= 1'b0;
      go(2'b10, 4'h4, 4'h3, 32'h4801);
      go(2'b01, 4'h4, 4'h3, 32'h0);
      go(2'b00, 4'h4, 4'h0, 32'h0);
      @(negedge ref_clk);
      chk(reg_rdata, 32'h4801);
      chk(ls, 32'h4801);
      wrap_up();
   end
   initial
   begin
      repeat (200) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end
endmodule : testbench
